// ===== sfe_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "sfe_defs.svh"

module sfe_top #(
   parameter int unsigned ADDR_W = `SFE_ADDR_W,
   parameter int unsigned SECTOR_WIPE_CYC =
      `SFE_SECTOR_WIPE_TIME_US * `SFE_CLK_MHZ,
   parameter int unsigned SMALL_BLOCK_WIPE_CYC =
      `SFE_SMALL_BLOCK_WIPE_TIME_US * `SFE_CLK_MHZ,
   parameter int unsigned LARGE_BLOCK_WIPE_CYC =
      `SFE_LARGE_BLOCK_WIPE_TIME_US * `SFE_CLK_MHZ,
   parameter int unsigned ARRAY_WIPE_CYC =
      `SFE_ARRAY_WIPE_TIME_US * `SFE_CLK_MHZ,
   parameter int unsigned PAGE_WRITE_CYC =
      `SFE_PAGE_WRITE_TIME_US * `SFE_CLK_MHZ
) (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic [3:0] io_in,
   input wire logic quad_cmd_mode,
   input wire logic [4:0] protect_level,
   input wire logic write_unlock_cmd,
   output var logic operation_active_flag,
   output var logic write_unlock_latch,
   output var logic wipe_req,
   output var sfe_pkg::sfe_op_t op_kind,
   output var logic [ADDR_W-1:0] wipe_base,
   output var logic prog_we,
   output var logic [ADDR_W-1:0] prog_addr,
   output var logic [7:0] prog_data
);
   import sfe_pkg::*;

   localparam int unsigned PAGE_LSB = `SFE_PAGE_LSB;

   // Page streaming must finish inside the page write cycle; the other timed cycles need only 2 clocks
   if (ADDR_W <= `SFE_LARGE_LSB || ADDR_W > 8 * `SFE_ADDR_BYTES) begin : g_bad_addr
      $error("ADDR_W out of range");
   end
   if (PAGE_WRITE_CYC < `SFE_PAGE_BYTES + 2 || SECTOR_WIPE_CYC < 2 ||
       SMALL_BLOCK_WIPE_CYC < 2 || LARGE_BLOCK_WIPE_CYC < 2 ||
       ARRAY_WIPE_CYC < 2) begin : g_bad_time
      $error("Cycle counts too short");
   end

   // Low-bit mask of the region an operation covers
   function automatic logic [ADDR_W-1:0] span_mask(input sfe_op_t k);
      logic [ADDR_W-1:0] ones;
      ones = '1;
      unique case (k)
         OP_SECTOR: span_mask = ~(ones << `SFE_SECTOR_LSB);
         OP_SMALL: span_mask = ~(ones << `SFE_SMALL_LSB);
         OP_LARGE: span_mask = ~(ones << `SFE_LARGE_LSB);
         OP_PAGE: span_mask = ~(ones << `SFE_PAGE_LSB);
         OP_ARRAY: span_mask = ones;
         default: span_mask = '0;
      endcase
   endfunction

   // Level n>0 guards the top 2^(n-1) 64K units; large n guards all
   function automatic logic is_guarded(input logic [ADDR_W-1:0] last,
                                       input logic [4:0] level);
      logic [ADDR_W-1:0] top;
      logic [5:0] sh;
      top = '1;
      sh = 6'(level) - 6'h1 + 6'(`SFE_PROTECT_UNIT_LSB);
      top = (sh >= 6'(ADDR_W)) ? '0 : (top << sh);
      is_guarded = (level != 5'h00) && ((last & top) == top);
   endfunction

   sfe_link_if lnk ();

   sfe_link u_link (
      .sclk(sclk),
      .reset_n(reset_n),
      .cs_n(cs_n),
      .io_in(io_in),
      .quad_cmd_mode(quad_cmd_mode),
      .lnk(lnk.link)
   );

   // Three-stage synchronisers: {cs_n, byte toggle, partial byte}
   logic [2:0] sync1;
   logic [2:0] sync2;
   logic [2:0] sync3;
   logic [2:0] lvl;
   logic [2:0] lvl_d;

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         sync1 <= 3'h4;
         sync2 <= 3'h4;
         sync3 <= 3'h4;
      end else begin
         sync1 <= {cs_n, lnk.byte_tgl, lnk.partial};
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         lvl <= 3'h4;
         lvl_d <= 3'h4;
      end else begin
         for (int i = 0; i < 3; i++) begin
            if (sync2[i] == sync3[i]) begin
               lvl[i] <= sync3[i];
            end
         end
         lvl_d <= lvl;
      end
   end

   logic cs_fall;
   logic cs_rise;
   logic byte_evt;
   logic partial_lvl;

   always_comb begin
      cs_fall = lvl_d[2] & ~lvl[2];
      cs_rise = ~lvl_d[2] & lvl[2];
      byte_evt = lvl_d[1] ^ lvl[1];
      partial_lvl = lvl[0];
   end

   sfe_state_t state;
   sfe_state_t next_state;
   logic [2:0] byte_cnt;
   logic [7:0] opcode;
   logic [ADDR_W-1:0] addr;
   logic [7:0] offset;
   logic [31:0] timer;
   logic [8:0] stream_idx;
   logic [7:0] page_buf [`SFE_PAGE_BYTES];
   logic [`SFE_PAGE_BYTES-1:0] filled;

   // Decision on the finished frame
   sfe_op_t cmd;
   logic cmd_ok;
   logic guarded;
   logic start_op;
   logic clear_latch;
   logic [ADDR_W-1:0] last_addr;
   logic [31:0] run_len;

   always_comb begin
      unique case (opcode)
         `SFE_OP_SECTOR: cmd = OP_SECTOR;
         `SFE_OP_SMALL: cmd = OP_SMALL;
         `SFE_OP_LARGE: cmd = OP_LARGE;
         `SFE_OP_ARRAY_A, `SFE_OP_ARRAY_B: cmd = OP_ARRAY;
         `SFE_OP_PAGE: cmd = OP_PAGE;
         default: cmd = OP_NONE;
      endcase
      unique case (cmd)
         OP_SECTOR, OP_SMALL, OP_LARGE:
            cmd_ok = (byte_cnt == 3'(1 + `SFE_ADDR_BYTES)) && !partial_lvl;
         OP_ARRAY: cmd_ok = (byte_cnt == 3'h1) && !partial_lvl;
         OP_PAGE:
            cmd_ok = (byte_cnt > 3'(1 + `SFE_ADDR_BYTES)) && !partial_lvl;
         default: cmd_ok = 1'b0;
      endcase
      last_addr = addr | span_mask(cmd);
      if (cmd == OP_ARRAY) begin
         guarded = (protect_level != 5'h00);
      end else begin
         guarded = is_guarded(last_addr, protect_level);
      end
      unique case (cmd)
         OP_SECTOR: run_len = SECTOR_WIPE_CYC;
         OP_SMALL: run_len = SMALL_BLOCK_WIPE_CYC;
         OP_LARGE: run_len = LARGE_BLOCK_WIPE_CYC;
         OP_ARRAY: run_len = ARRAY_WIPE_CYC;
         default: run_len = PAGE_WRITE_CYC;
      endcase
      start_op = (state == ST_DECIDE) && write_unlock_latch && cmd_ok && !guarded;
      // Small block keeps the latch rule even when guarded
      clear_latch = ((state == ST_RUN) && (timer == 32'h0)) ||
                    ((state == ST_DECIDE) && write_unlock_latch && cmd_ok &&
                     guarded && (cmd == OP_SMALL));
   end

   always_comb begin
      next_state = state;
      unique case (state)
         ST_IDLE: if (cs_fall) begin
            next_state = ST_FRAME;
         end
         ST_FRAME: if (cs_rise) begin
            next_state = ST_SETTLE;
         end
         ST_SETTLE: next_state = ST_DECIDE;
         ST_DECIDE: next_state = start_op ? ST_RUN : ST_IDLE;
         ST_RUN: if (timer == 32'h0) begin
            next_state = ST_IDLE;
         end
      endcase
   end

   // Frames starting while busy never enter ST_FRAME
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Frame collection; bytes still landing just after cs rise are kept
   logic collecting;
   logic data_byte;

   always_comb begin
      collecting = byte_evt && ((state == ST_FRAME) || (state == ST_SETTLE));
      data_byte = collecting && (byte_cnt > 3'(`SFE_ADDR_BYTES));
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         byte_cnt <= 3'h0;
         opcode <= 8'h00;
         addr <= '0;
         offset <= 8'h00;
      end else if (state == ST_IDLE && cs_fall) begin
         byte_cnt <= 3'h0;
      end else if (collecting) begin
         // Saturates: only "more than address" matters afterwards
         if (byte_cnt != 3'h7) begin
            byte_cnt <= byte_cnt + 3'h1;
         end
         if (byte_cnt == 3'h0) begin
            opcode <= lnk.byte_data;
         end else if (byte_cnt <= 3'(`SFE_ADDR_BYTES)) begin
            addr <= {addr[ADDR_W-9:0], lnk.byte_data};
            offset <= lnk.byte_data;
         end else begin
            offset <= offset + 8'h01;
         end
      end
   end

   // Later bytes overwrite earlier ones at the same offset
   always_ff @(posedge clock) begin
      if (data_byte) begin
         page_buf[offset] <= lnk.byte_data;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         filled <= '0;
      end else if (state == ST_IDLE && cs_fall) begin
         filled <= '0;
      end else if (data_byte) begin
         filled[offset] <= 1'b1;
      end
   end

   // Self-timed cycle
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         timer <= 32'h0;
         operation_active_flag <= 1'b0;
      end else if (start_op) begin
         timer <= run_len - 32'h1;
         operation_active_flag <= 1'b1;
      end else if (state == ST_RUN) begin
         if (timer == 32'h0) begin
            operation_active_flag <= 1'b0;
         end else begin
            timer <= timer - 32'h1;
         end
      end
   end

   // Set wins over the end-of-cycle clear
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         write_unlock_latch <= 1'b0;
      end else if (write_unlock_cmd) begin
         write_unlock_latch <= 1'b1;
      end else if (clear_latch) begin
         write_unlock_latch <= 1'b0;
      end
   end

   // Erase request to the array, one pulse at cycle start
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         wipe_req <= 1'b0;
         op_kind <= OP_NONE;
         wipe_base <= '0;
      end else begin
         wipe_req <= start_op && (cmd != OP_PAGE);
         if (start_op) begin
            op_kind <= cmd;
            wipe_base <= addr & ~span_mask(cmd);
         end
      end
   end

   // Page bytes streamed once per cycle, only offsets that were sent
   logic streaming;

   always_comb begin
      streaming = (state == ST_RUN) && (op_kind == OP_PAGE) &&
                  (stream_idx < 9'(`SFE_PAGE_BYTES));
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         stream_idx <= 9'h000;
      end else if (start_op) begin
         stream_idx <= 9'h000;
      end else if (streaming) begin
         stream_idx <= stream_idx + 9'h001;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         prog_we <= 1'b0;
         prog_addr <= '0;
         prog_data <= 8'h00;
      end else begin
         prog_we <= streaming && filled[stream_idx[7:0]];
         prog_addr <= {addr[ADDR_W-1:PAGE_LSB], stream_idx[7:0]};
         prog_data <= page_buf[stream_idx[7:0]];
      end
   end

endmodule

`default_nettype wire

// ===== sfe_defs.svh
`ifndef SFE_DEFS_SVH
`define SFE_DEFS_SVH

// Opcodes
`define SFE_OP_SECTOR 8'h20
`define SFE_OP_SMALL 8'h52
`define SFE_OP_LARGE 8'hd8
`define SFE_OP_ARRAY_A 8'h60
`define SFE_OP_ARRAY_B 8'hc7
`define SFE_OP_PAGE 8'h02

// Geometry
`define SFE_ADDR_W 24
`define SFE_ADDR_BYTES 3
`define SFE_SECTOR_LSB 12
`define SFE_SMALL_LSB 15
`define SFE_LARGE_LSB 16
`define SFE_PAGE_LSB 8
`define SFE_PAGE_BYTES 256
`define SFE_PROTECT_UNIT_LSB 16
`define SFE_ERASED_BYTE 8'hff

// Link
`define SFE_BYTE_BITS 8
`define SFE_QUAD_STEP 3'h4
`define SFE_SINGLE_STEP 3'h1

// Clock in MHz, then self-timed cycles in microseconds
`define SFE_CLK_MHZ 100
`define SFE_SECTOR_WIPE_TIME_US 50000
`define SFE_SMALL_BLOCK_WIPE_TIME_US 150000
`define SFE_LARGE_BLOCK_WIPE_TIME_US 250000
`define SFE_ARRAY_WIPE_TIME_US 10000000
`define SFE_PAGE_WRITE_TIME_US 1000

`endif

// ===== sfe_pkg.sv
package sfe_pkg;

   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_FRAME = 5'h02,
      ST_SETTLE = 5'h04,
      ST_DECIDE = 5'h08,
      ST_RUN = 5'h10
   } sfe_state_t;

   typedef enum logic [2:0] {
      OP_NONE = 3'h0,
      OP_SECTOR = 3'h1,
      OP_SMALL = 3'h2,
      OP_LARGE = 3'h3,
      OP_ARRAY = 3'h4,
      OP_PAGE = 3'h5
   } sfe_op_t;

endpackage

// ===== sfe_link_if.sv
`timescale 1ns/1ps
`default_nettype none

interface sfe_link_if;
   logic [7:0] byte_data;
   logic byte_tgl;
   logic partial;

   modport link (output byte_data, output byte_tgl, output partial);
   modport core (input byte_data, input byte_tgl, input partial);
endinterface

`default_nettype wire

// ===== sfe_link.sv
`timescale 1ns/1ps
`default_nettype none
`include "sfe_defs.svh"

module sfe_link (
   input wire logic sclk,
   input wire logic reset_n,
   input wire logic cs_n,
   input wire logic [3:0] io_in,
   input wire logic quad_cmd_mode,
   sfe_link_if.link lnk
);
   logic fresh;
   logic quad_s1;
   logic quad_s2;
   logic quad_s3;
   logic quad_lvl;
   logic [2:0] bit_cnt;
   logic [7:0] shift;
   logic [2:0] pos;
   logic [2:0] next_cnt;
   logic [7:0] assembled;

   // Frame start marker; sclk may be stopped while cs_n is high
   always_ff @(posedge sclk or posedge cs_n) begin
      if (cs_n) begin
         fresh <= 1'b1;
      end else begin
         fresh <= 1'b0;
      end
   end

   always_ff @(posedge sclk or negedge reset_n) begin
      if (!reset_n) begin
         quad_s1 <= 1'b0;
         quad_s2 <= 1'b0;
         quad_s3 <= 1'b0;
         quad_lvl <= 1'b0;
      end else begin
         quad_s1 <= quad_cmd_mode;
         quad_s2 <= quad_s1;
         quad_s3 <= quad_s2;
         // Mode counts once the last two stages agree
         if (quad_s2 == quad_s3) begin
            quad_lvl <= quad_s3;
         end
      end
   end

   always_comb begin
      pos = fresh ? 3'h0 : bit_cnt;
      if (quad_lvl) begin
         next_cnt = pos + `SFE_QUAD_STEP;
         assembled = {shift[3:0], io_in};
      end else begin
         // Upper lines ignored in single-line mode
         next_cnt = pos + `SFE_SINGLE_STEP;
         assembled = {shift[6:0], io_in[0]};
      end
   end

   // Count survives cs_n rise so the core can judge alignment
   always_ff @(posedge sclk or negedge reset_n) begin
      if (!reset_n) begin
         bit_cnt <= 3'h0;
         shift <= 8'h00;
         lnk.partial <= 1'b0;
      end else begin
         bit_cnt <= next_cnt;
         shift <= assembled;
         lnk.partial <= (next_cnt != 3'h0);
      end
   end

   // Byte held stable for a whole byte time while the toggle crosses
   always_ff @(posedge sclk or negedge reset_n) begin
      if (!reset_n) begin
         lnk.byte_data <= 8'h00;
         lnk.byte_tgl <= 1'b0;
      end else if (next_cnt == 3'h0) begin
         lnk.byte_data <= assembled;
         lnk.byte_tgl <= ~lnk.byte_tgl;
      end
   end

endmodule

`default_nettype wire

// ===== sfe_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module sfe_monitor #(
   parameter int unsigned SECTOR_WIPE_CYC = 50,
   parameter int unsigned SMALL_BLOCK_WIPE_CYC = 50,
   parameter int unsigned LARGE_BLOCK_WIPE_CYC = 50,
   parameter int unsigned ARRAY_WIPE_CYC = 50,
   parameter int unsigned PAGE_WRITE_CYC = 300
) (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic [4:0] protect_level,
   input wire logic write_unlock_cmd,
   input wire logic operation_active_flag,
   input wire logic write_unlock_latch,
   input wire logic wipe_req,
   input wire sfe_pkg::sfe_op_t op_kind,
   input wire logic [23:0] wipe_base,
   input wire logic prog_we
);
   import sfe_pkg::*;
   logic [31:0] run_cnt;
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   // Counter instead of a long repetition, which the tools cannot unroll
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         run_cnt <= 32'h0;
      end else begin
         run_cnt <= operation_active_flag ? run_cnt + 32'h1 : 32'h0;
      end
   end
   function automatic logic [31:0] run_len(input sfe_op_t k);
      case (k)
         OP_SECTOR: return SECTOR_WIPE_CYC;
         OP_SMALL: return SMALL_BLOCK_WIPE_CYC;
         OP_LARGE: return LARGE_BLOCK_WIPE_CYC;
         OP_ARRAY: return ARRAY_WIPE_CYC;
         default: return PAGE_WRITE_CYC;
      endcase
   endfunction
   start_on_idle_a: assert property (wipe_req |-> $rose(operation_active_flag))
      else $error("wipe start without fresh active flag");
   start_pulse_a: assert property (wipe_req |=> !wipe_req)
      else $error("wipe start longer than one cycle");
   sector_align_a: assert property (wipe_req && op_kind == OP_SECTOR |->
      wipe_base[11:0] == 12'h0)
      else $error("sector base misaligned");
   small_align_a: assert property (wipe_req && op_kind == OP_SMALL |->
      wipe_base[14:0] == 15'h0)
      else $error("small block base misaligned");
   large_align_a: assert property (wipe_req && op_kind == OP_LARGE |->
      wipe_base[15:0] == 16'h0)
      else $error("large block base misaligned");
   array_clear_a: assert property (wipe_req && op_kind == OP_ARRAY |->
      wipe_base == 24'h0 && protect_level == 5'h0)
      else $error("array wipe with protection or base");
   unlock_needed_a: assert property ($rose(operation_active_flag) |->
      $past(write_unlock_latch))
      else $error("operation started with latch clear");
   latch_drop_a: assert property ($fell(operation_active_flag) |->
      !write_unlock_latch || $past(write_unlock_cmd))
      else $error("latch not cleared at end of cycle");
   run_length_a: assert property ($fell(operation_active_flag) |->
      run_cnt == run_len(op_kind))
      else $error("self-timed cycle length wrong");
   prog_in_run_a: assert property (prog_we |-> operation_active_flag && op_kind == OP_PAGE)
      else $error("byte programmed outside page cycle");
endmodule
bind sfe_top sfe_monitor #(.SECTOR_WIPE_CYC(SECTOR_WIPE_CYC),
   .SMALL_BLOCK_WIPE_CYC(SMALL_BLOCK_WIPE_CYC), .LARGE_BLOCK_WIPE_CYC(LARGE_BLOCK_WIPE_CYC),
   .ARRAY_WIPE_CYC(ARRAY_WIPE_CYC), .PAGE_WRITE_CYC(PAGE_WRITE_CYC)) mon (.clock, .reset_n,
   .protect_level, .write_unlock_cmd, .operation_active_flag, .write_unlock_latch,
   .wipe_req, .op_kind, .wipe_base, .prog_we);
`default_nettype wire

// ===== sfe_host.sv
`timescale 1ns/1ps
`default_nettype none
module sfe_host (
   output logic sclk,
   output logic cs_n,
   output logic [3:0] io_in,
   input wire logic quad_cmd_mode
);
   logic qm;
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      io_in = 4'h5;
      qm = 1'b0;
   end
   task automatic bit_out(input logic [3:0] v);
      io_in = v;
      #15 sclk = 1'b1;
      #15 sclk = 1'b0;
   endtask
   // Whole bytes MSB first; xb extra clocks make a partial byte
   task automatic frame(input logic [7:0] b[$], input int xb);
      // Mode change needs four idle link edges before the frame
      if (quad_cmd_mode !== qm) repeat (4) bit_out(io_in);
      qm = quad_cmd_mode;
      cs_n = 1'b0;
      #37;
      foreach (b[i]) begin
         for (int k = 7; k >= 0; k -= (qm ? 4 : 1)) begin
            // Upper lines toggle in single mode, so ignoring them is tested
            bit_out(qm ? b[i][k-:4] : {~io_in[3:1], b[i][k]});
         end
      end
      repeat (xb) bit_out(~io_in);
      #20 cs_n = 1'b1;
      io_in = ~io_in;
      #100;
   endtask
endmodule
`default_nettype wire

// ===== serial_flash_erase_program_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module serial_flash_erase_program_tb_top;
   import sfe_pkg::*;
   logic clock, reset_n, sclk, cs_n, quad_cmd_mode, write_unlock_cmd, flag, latch, wipe_req;
   logic prog_we;
   logic [3:0] io_in;
   logic [4:0] protect_level;
   sfe_op_t op_kind, got_kind;
   logic [23:0] wipe_base, prog_addr, got_base, a;
   logic [7:0] prog_data;
   logic [7:0] mem [int];
   logic [7:0] q[$];
   int failures, samples_checked, nwipe, nprog;

   localparam int unsigned SHORT_CYC = 50;
   localparam int unsigned LONG_CYC = 600;
   localparam int unsigned PAGE_CYC = 300;
   sfe_top #(.SECTOR_WIPE_CYC(SHORT_CYC), .SMALL_BLOCK_WIPE_CYC(SHORT_CYC),
      .LARGE_BLOCK_WIPE_CYC(LONG_CYC), .ARRAY_WIPE_CYC(SHORT_CYC), .PAGE_WRITE_CYC(PAGE_CYC))
      DUT (.clock, .reset_n, .sclk, .cs_n, .io_in,
      .quad_cmd_mode, .protect_level, .write_unlock_cmd, .operation_active_flag(flag),
      .write_unlock_latch(latch), .wipe_req, .op_kind, .wipe_base, .prog_we, .prog_addr,
      .prog_data);
   sfe_host host (.sclk, .cs_n, .io_in, .quad_cmd_mode);

   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   always @(posedge clock) begin
      if (wipe_req === 1'b1) begin
         nwipe++;
         got_kind = op_kind;
         got_base = wipe_base;
      end
      if (prog_we === 1'b1) begin
         nprog++;
         mem[prog_addr] = prog_data;
      end
   end
   task check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task print_verdict;
      $display("failures=%0d samples_checked=%0d", failures, samples_checked);
      if (failures == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task send(input int xb, input bit unl);
      if (unl) begin
         @(posedge clock) write_unlock_cmd <= 1'b1;
         @(posedge clock) write_unlock_cmd <= 1'b0;
      end
      host.frame(q, xb);
   endtask
   task settle;
      repeat (12) @(posedge clock);
      for (int i = 0; i < 800 && flag !== 1'b0; i++) @(posedge clock);
      check(flag, 0);
   endtask
   task run(input int xb, input bit unl);
      nwipe = 0;
      nprog = 0;
      mem.delete();
      send(xb, unl);
      settle();
   endtask
   initial begin
      #800000;
      failures++;
      print_verdict();
   end
   initial begin
      reset_n = 1'b0;
      quad_cmd_mode = 1'b0;
      protect_level = 5'h0;
      write_unlock_cmd = 1'b0;
      a = 24'h5ab7c3;
      repeat (8) @(posedge clock);
      reset_n <= 1'b1;
      repeat (4) @(posedge clock);
      // Every erase opcode; the last two in quad command mode
      q.delete();
      for (int i = 0; i < 6; i++) begin
         @(posedge clock) quad_cmd_mode <= (i > 3);
         case (i)
            1: q = {8'h52, a[23:16], a[15:8], a[7:0]};
            2: q = {8'hd8, a[23:16], a[15:8], a[7:0]};
            3: q = {8'h60};
            4: q = {8'hc7};
            default: q = {8'h20, a[23:16], a[15:8], a[7:0]};
         endcase
         run(0, 1);
         check(nwipe, 1);
         check(got_kind, i == 1 ? OP_SMALL : i == 2 ? OP_LARGE : i > 2 && i < 5 ? OP_ARRAY
            : OP_SECTOR);
         check(got_base, i == 1 ? 24'h5a8000 : i == 2 ? 24'h5a0000 : i > 2 && i < 5 ? 24'h0
            : 24'h5ab000);
         check(latch, 0);
      end
      @(posedge clock) quad_cmd_mode <= 1'b0;
      q = {8'h20, 8'h00, 8'h10, 8'h00};
      run(0, 0);
      check(nwipe, 0);
      run(4, 1);
      check(nwipe, 0);
      q.push_back(8'h77);
      run(0, 1);
      check(nwipe, 0);
      q = {8'h02, 8'h00, 8'h13, 8'h00, 8'haa};
      run(3, 1);
      check(nprog, 0);
      // Top 64K block protected; only the small block wipe drops the latch
      protect_level <= 5'h1;
      for (int i = 0; i < 5; i++) begin
         case (i)
            0: q = {8'h20, 8'hff, 8'hf1, 8'h23};
            1: q = {8'h52, 8'hff, 8'h80, 8'h00};
            2: q = {8'hd8, 8'hff, 8'h45, 8'h67};
            3: q = {8'h60};
            default: q = {8'h02, 8'hff, 8'h00, 8'h10, 8'h00};
         endcase
         run(0, 1);
         check(nwipe + nprog, 0);
         check(latch, i != 1);
      end
      // Level two guards the top two 64K units only
      protect_level <= 5'h2;
      q = {8'h20, 8'hfe, 8'h00, 8'h00};
      run(0, 1);
      check(nwipe, 0);
      q[1] = 8'hfd;
      run(0, 1);
      check(nwipe, 1);
      check(got_base, 24'hfd0000);
      protect_level <= 5'h0;
      q = {8'h02, 8'h00, 8'h12, 8'hf0};
      for (int i = 0; i < 20; i++) q.push_back(8'(i + 8'h40));
      run(0, 1);
      check(nprog, 20);
      for (int i = 0; i < 20; i++) begin
         check(mem.exists(32'h1200 | ((32'hf0 + i) & 32'hff)) ? mem[32'h1200 |
            ((32'hf0 + i) & 32'hff)] : 8'hxx, 8'(i + 8'h40));
      end
      check(mem.exists(32'h1210), 0);
      q = {8'h02, 8'h00, 8'h34, 8'h00};
      for (int i = 0; i < 260; i++) q.push_back(8'(i) ^ (i > 255 ? 8'haa : 8'h00));
      run(0, 1);
      check(nprog, 256);
      for (int i = 0; i < 5; i++) begin
         check(mem.exists(32'h3400 + i) ? mem[32'h3400 + i] : 8'hxx,
            8'(i) ^ (i < 4 ? 8'haa : 8'h00));
      end
      // Second command lands while the long large block wipe runs
      q = {8'hd8, 8'h02, 8'h00, 8'h00};
      nwipe = 0;
      send(0, 1);
      q = {8'h20, 8'h00, 8'h10, 8'h00};
      send(0, 1);
      settle();
      check(nwipe, 1);
      check(got_kind, OP_LARGE);
      print_verdict();
   end
endmodule
`default_nettype wire
